// ===== scpr_fifo.sv
// word fifo between the flash fetch side and the bit shifter
`timescale 1ns/1ps
module scpr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("scpr_fifo: depth must be a power of two, width at least one");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // honest flags from the fill count
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count, flush empties at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + AW'(push);
            rd_q  <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : scpr_fifo

// ===== scpr_fpga_model.sv
// loader-side model: flash array responder and master-serial bit capture
`timescale 1ns/1ps
module scpr_fpga_model (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        slow,
    // flash array read port
    input  wire logic                        mem_rd_req,
    input  wire logic [scpr_pkg::ADDR_W-1:0] mem_addr,
    output logic                             mem_rd_ack,
    output logic [15:0]                      mem_rd_data,
    // configuration port lines
    input  wire logic                        sck_line,
    input  wire logic                        data_line,
    output logic [31:0]                      shift_q,
    output int                               bits_q
);
    import scpr_pkg::*;

    logic [3:0] wait_q;
    logic       sck_q;

    // answer each read after a short or a long wait, one word per ack
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_ack  <= 1'b0;
            mem_rd_data <= 16'h0000;
            wait_q      <= 4'h0;
        end else begin
            mem_rd_ack  <= 1'b0;
            mem_rd_data <= ~mem_rd_data; // word inverted every cycle between answers
            if (mem_rd_req && !mem_rd_ack) begin
                if (wait_q >= (slow ? 4'h6 : 4'h0)) begin
                    mem_rd_ack  <= 1'b1;
                    mem_rd_data <= mem_addr[15:0] ^ {mem_addr[20:16], 11'h000} ^ 16'hA5C3;
                    wait_q      <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end

    // sample the data line on each rising serial clock, as the loader does
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q   <= 1'b0;
            shift_q <= 32'h00000000;
            bits_q  <= 0;
        end else begin
            sck_q <= sck_line;
            if (sck_line && !sck_q) begin
                shift_q <= {shift_q[30:0], data_line};
                bits_q  <= bits_q + 1;
            end
        end
    end
endmodule : scpr_fpga_model

// ===== scpr_pkg.sv
// constants and types shared by the serial configuration readout block
package scpr_pkg;

    // ==========================================================
    // address map of the stored bitstream (word addresses)
    localparam int              ADDR_W       = 21;
    localparam logic [20:0]     ADDR_ZERO    = 21'h000000;
    localparam logic [20:0]     PAGE_SIZE    = 21'h080000;
    localparam logic [20:0]     PAGE_TOP_OFS = 21'h07FFFF;
    localparam logic [20:0]     DEV_TOP      = 21'h1FFFFF;
    localparam int              PAGE_COUNT   = 4;

    // ==========================================================
    // serial clock timing
    localparam int              REF_PERIOD_NS = 25;
    localparam int              SCK_PERIOD_NS = 200;
    localparam int              SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * REF_PERIOD_NS);

    // ==========================================================
    // positions inside the synchronised pin vector
    localparam int              PIN_W        = 9;
    localparam int              PIN_OE       = 0;
    localparam int              PIN_CS_N     = 1;
    localparam int              PIN_CFG_N    = 2;
    localparam int              PIN_PAGE_EN  = 3;
    localparam int              PIN_SEL_LO   = 4;
    localparam int              PIN_SEL_HI   = 5;
    localparam int              PIN_DEV_SEL  = 6;
    localparam int              PIN_SCK      = 7;
    localparam int              PIN_DATA     = 8;

    // ==========================================================
    // readout sequencer states
    typedef enum logic [1:0] {
        SCPR_READ = 2'b00,
        SCPR_DONE = 2'b01,
        SCPR_PROG = 2'b10
    } scpr_state_type;

endpackage : scpr_pkg

// ===== scpr_readout.sv
// readout control of a serial configuration flash feeding a master-serial loader
`timescale 1ns/1ps

module scpr_readout
    import scpr_pkg::*;
#(
    parameter int WORD_W     = 16,
    parameter int FIFO_DEPTH = 16
) (
    // clock and power-up reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    // control pins from the loader
    input  wire logic                      reset_oe,
    input  wire logic                      chip_select_n,
    input  wire logic                      config_mode_select_n,
    input  wire logic                      page_enable,
    input  wire logic [1:0]                page_select,
    // serial data pin
    input  wire logic                      data_in,
    output logic                           data_out,
    output logic                           data_oe_n,
    // serial clock pin
    input  wire logic                      serial_clock_in,
    output logic                           serial_clock_out,
    output logic                           serial_clock_oe_n,
    // cascade pin, device select while programming
    input  wire logic                      program_device_select,
    output logic                           cascade_out_n,
    output logic                           cascade_oe_n,
    // open-collector ready pin
    output logic                           ready_out,
    output logic                           ready_oe_n,
    // status
    output logic                           standby,
    // two-wire programming engine side
    input  wire logic                      prog_data_low,
    output logic                           in_system_programming,
    output logic                           prog_select,
    output logic                           prog_clock,
    output logic                           prog_data,
    // flash array read port
    output logic                           mem_rd_req,
    output logic [scpr_pkg::ADDR_W-1:0]    mem_addr,
    input  wire logic                      mem_rd_ack,
    input  wire logic [WORD_W-1:0]         mem_rd_data
);
    localparam int BIT_W = (WORD_W > 1) ? $clog2(WORD_W) : 1;
    localparam int DIV_W = $clog2(SCK_HALF_CYC + 1);

    initial begin
        if (WORD_W < 2 || (1 << BIT_W) != WORD_W || ADDR_W != 21 || SCK_HALF_CYC < 1) begin
            $error("scpr_readout: word width must be a power of two, address 21 bits");
        end
    end

    // ==========================================================
    // page decode

    // first word of the chosen range
    function automatic logic [ADDR_W-1:0] page_base(input logic en, input logic [1:0] sel);
        logic [ADDR_W-1:0] b;
        b = ADDR_ZERO;
        if (en) begin
            b = PAGE_SIZE * sel;
        end
        return b;
    endfunction : page_base

    // last word of the chosen range
    function automatic logic [ADDR_W-1:0] page_top(input logic en, input logic [1:0] sel);
        logic [ADDR_W-1:0] t;
        t = DEV_TOP;
        if (en) begin
            t = page_base(en, sel) + PAGE_TOP_OFS;
        end
        return t;
    endfunction : page_top

    // ==========================================================
    // reset release and pin synchronisers

    logic             rst_meta_q;
    logic             rst_q;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_q;
    wire  [PIN_W-1:0] pin_raw = {data_in, serial_clock_in, program_device_select, page_select,
                                 page_enable, config_mode_select_n, chip_select_n, reset_oe};

    // two flops release reset and sample every pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
            pin_meta_q <= '0;
            pin_q      <= '0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
            pin_meta_q <= pin_raw;
            pin_q      <= pin_meta_q;
        end
    end

    // ==========================================================
    // mode decode

    scpr_state_type    state_q;
    scpr_state_type    state_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] top_q;
    logic [BIT_W-1:0]  bit_q;
    logic [DIV_W-1:0]  div_q;
    logic              sck_q;
    logic              fifo_valid;
    logic [WORD_W-1:0] fifo_word;
    logic              fifo_in_ready;

    wire prog_mode = ~pin_q[PIN_CFG_N];
    wire oe_s      = pin_q[PIN_OE];
    wire cs_n_s    = pin_q[PIN_CS_N];
    wire clr       = prog_mode | ~oe_s;
    wire selected  = ~prog_mode & oe_s & ~cs_n_s;
    wire enable    = selected & (state_q == SCPR_READ);
    wire div_end   = (div_q == DIV_W'(SCK_HALF_CYC - 1));
    wire run_clk   = enable & fifo_valid;                      // stalls when fifo runs dry
    wire advance   = run_clk & div_end & sck_q;                // falling clock edge
    wire word_end  = (bit_q == BIT_W'(WORD_W - 1));
    wire last_bit  = word_end & (addr_q == top_q);
    wire pop       = advance & word_end;
    wire page_en_m = pin_q[PIN_PAGE_EN] & ~prog_mode;
    wire [1:0] sel_s = {pin_q[PIN_SEL_HI], pin_q[PIN_SEL_LO]};

    // next sequencer state
    always_comb begin
        state_d = state_q;
        if (prog_mode) begin
            state_d = SCPR_PROG;
        end else if (clr) begin
            state_d = SCPR_READ;
        end else if (advance && last_bit) begin
            state_d = SCPR_DONE;
        end
    end

    // ==========================================================
    // address, bit counter and serial clock

    // counters cleared by reset/oe low and held while deselected
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            state_q <= SCPR_READ;
            addr_q  <= ADDR_ZERO;
            base_q  <= ADDR_ZERO;
            top_q   <= DEV_TOP;
            bit_q   <= '0;
            div_q   <= '0;
            sck_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (clr) begin
                addr_q <= page_base(page_en_m, sel_s);
                base_q <= page_base(page_en_m, sel_s);
                top_q  <= page_top(page_en_m, sel_s);
                bit_q  <= '0;
                div_q  <= '0;
                sck_q  <= 1'b0;
            end else if (run_clk) begin
                div_q <= div_end ? '0 : div_q + 1'b1;
                if (div_end) begin
                    sck_q <= ~sck_q;
                end
                if (advance) begin
                    bit_q <= bit_q + 1'b1;
                    if (word_end && !last_bit) begin
                        addr_q <= addr_q + 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // flash fetch into the fifo

    logic [ADDR_W-1:0] fetch_q;
    logic              fetch_done_q;
    logic              stale_q;
    logic              req_q;
    logic [ADDR_W-1:0] mem_addr_q;
    // no array reads while deselected: standby draws no fetch traffic and the
    // fifo stays empty until the loader selects the device
    wire               issue = ~req_q & ~fetch_done_q & fifo_in_ready & ~clr & ~cs_n_s;
    wire               push  = mem_rd_ack & req_q & ~stale_q & ~clr;

    // a read left pending across a clear is marked stale and dropped
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            fetch_q      <= ADDR_ZERO;
            fetch_done_q <= 1'b0;
            stale_q      <= 1'b0;
            req_q        <= 1'b0;
            mem_addr_q   <= ADDR_ZERO;
        end else begin
            if (mem_rd_ack && req_q) begin
                req_q   <= 1'b0;
                stale_q <= 1'b0;
                if (push) begin
                    fetch_done_q <= (fetch_q == top_q);
                    fetch_q      <= fetch_q + 1'b1;
                end
            end
            if (clr) begin
                fetch_q      <= page_base(page_en_m, sel_s);
                fetch_done_q <= 1'b0;
                if (req_q && !mem_rd_ack) begin
                    stale_q <= 1'b1;
                end
            end else if (issue) begin
                req_q      <= 1'b1;
                mem_addr_q <= fetch_q;
            end
        end
    end

    scpr_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_q),
        .flush     (clr),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_word)
    );

    // ==========================================================
    // pin drivers, all registered except ready_out, which is tied low

    logic data_out_q;
    logic data_oe_n_q;
    logic sck_oe_n_q;
    logic casc_n_q;
    logic casc_oe_n_q;
    logic ready_oe_n_q;
    logic standby_q;
    logic prog_mode_q;
    logic psel_q;
    logic pclk_q;
    logic pdata_q;

    wire in_done   = (state_q == SCPR_DONE);
    wire data_bit  = fifo_word[BIT_W'(WORD_W - 1) - bit_q];    // first bit is the msb
    wire data_oe_d = prog_mode ? ~prog_data_low : ~enable;

    // output flops
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            data_out_q   <= 1'b0;
            data_oe_n_q  <= 1'b1;
            sck_oe_n_q   <= 1'b1;
            casc_n_q     <= 1'b1;
            casc_oe_n_q  <= 1'b1;
            ready_oe_n_q <= 1'b0;
            standby_q    <= 1'b0;
            prog_mode_q  <= 1'b0;
            psel_q       <= 1'b0;
            pclk_q       <= 1'b0;
            pdata_q      <= 1'b0;
        end else begin
            data_out_q   <= ~prog_mode & data_bit;                // open-collector pulls low
            data_oe_n_q  <= data_oe_d;
            sck_oe_n_q   <= prog_mode;
            casc_n_q     <= ~(in_done & ~cs_n_s & ~prog_mode);
            casc_oe_n_q  <= prog_mode;
            ready_oe_n_q <= 1'b1;
            standby_q    <= ~prog_mode & cs_n_s;
            prog_mode_q  <= prog_mode;
            psel_q       <= prog_mode & pin_q[PIN_DEV_SEL];
            pclk_q       <= prog_mode & pin_q[PIN_SCK];
            pdata_q      <= prog_mode & pin_q[PIN_DATA];
        end
    end

    assign data_out              = data_out_q;
    assign data_oe_n             = data_oe_n_q;
    assign serial_clock_out      = sck_q;
    assign serial_clock_oe_n     = sck_oe_n_q;
    assign cascade_out_n         = casc_n_q;
    assign cascade_oe_n          = casc_oe_n_q;
    assign ready_out             = 1'b0;
    assign ready_oe_n            = ready_oe_n_q;
    assign standby               = standby_q;
    assign in_system_programming = prog_mode_q;
    assign prog_select           = psel_q;
    assign prog_clock            = pclk_q;
    assign prog_data             = pdata_q;
    assign mem_rd_req            = req_q;
    assign mem_addr              = mem_addr_q;

    // ==========================================================
    // checks

    clear_counters_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (!prog_mode && !oe_s) |=> (bit_q == '0 && addr_q == base_q && data_oe_n_q))
        else $error("counters not cleared by reset/oe low");

    // a clear in standby still reloads the counter, otherwise it must hold
    standby_float_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (!prog_mode && cs_n_s) |=>
        (data_oe_n_q && standby_q && addr_q == ($past(clr) ? base_q : $past(addr_q))))
        else $error("data driven or counter moved in standby");

    drive_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (state_q == SCPR_READ && selected) |=> !data_oe_n_q)
        else $error("driver not enabled while selected");

    done_float_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (advance && last_bit && !clr) |=> ##1 (data_oe_n_q && !cascade_out_n))
        else $error("data not floated after last bit");

    cascade_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (in_done && !prog_mode) |=> (cascade_out_n == $past(cs_n_s)))
        else $error("cascade does not follow select after readout");

    addr_step_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (advance && word_end && !last_bit && !clr) |=>
        (addr_q == $past(addr_q) + 1'b1 && bit_q == '0))
        else $error("address did not step on bit wrap");

    prog_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        prog_mode [*2] |-> (serial_clock_oe_n && cascade_oe_n && !data_out))
        else $error("clock or cascade driven in programming mode");

    ready_release_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        $rose(rst_q) |-> (!ready_oe_n ##1 ready_oe_n))
        else $error("ready not released after power-up");

    page_range_a: assert property (@(posedge ref_clk) disable iff (!rst_q)
        (clr && page_en_m && sel_s == 2'b11) |=> (base_q == 21'h180000 && top_q == DEV_TOP))
        else $error("top page range wrong");

endmodule : scpr_readout

// ===== tb_scpr_readout.sv
// self-checking bench of the serial configuration readout block
`timescale 1ns/1ps
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin miscompares++; \
    $display("unexpected %0t: got %h want %h", $time, got, want); end end
module tb_scpr_readout;
    import scpr_pkg::*;

    // ==========================================================
    // pins, far-side drives and bookkeeping
    logic        ref_clk = 1'b0, rst_n = 1'b0, reset_oe = 1'b1, chip_select_n = 1'b1;
    logic        config_mode_select_n = 1'b1, page_enable = 1'b0, prog_data_low = 1'b0;
    logic [1:0]  page_select = 2'b00;
    logic        sck_drv = 1'b0, sel_drv = 1'b1, data_drv = 1'b1, slow = 1'b0;
    logic        data_out, data_oe_n, serial_clock_out, serial_clock_oe_n, cascade_out_n;
    logic        cascade_oe_n, ready_out, ready_oe_n, standby, in_system_programming;
    logic        prog_select, prog_clock, prog_data, mem_rd_req, mem_rd_ack;
    logic [20:0] mem_addr;
    logic [15:0] mem_rd_data;
    logic [31:0] shift_q;
    int          bits_q, base, k, miscompares = 0, checks = 0;
    wire         data_line = (data_oe_n | data_out) & data_drv; // pulled up when released
    wire         sck_line  = serial_clock_oe_n ? sck_drv : serial_clock_out;
    wire         casc_line = cascade_oe_n ? sel_drv : cascade_out_n;

    // clock of 25 ns
    always #12.5 ref_clk = ~ref_clk;

    scpr_readout u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reset_oe(reset_oe),
        .chip_select_n(chip_select_n), .config_mode_select_n(config_mode_select_n),
        .page_enable(page_enable), .page_select(page_select), .data_in(data_line),
        .data_out(data_out), .data_oe_n(data_oe_n), .serial_clock_in(sck_line),
        .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n),
        .program_device_select(casc_line), .cascade_out_n(cascade_out_n),
        .cascade_oe_n(cascade_oe_n), .ready_out(ready_out), .ready_oe_n(ready_oe_n),
        .standby(standby), .prog_data_low(prog_data_low),
        .in_system_programming(in_system_programming), .prog_select(prog_select),
        .prog_clock(prog_clock), .prog_data(prog_data), .mem_rd_req(mem_rd_req),
        .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));

    scpr_fpga_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
        .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack),
        .mem_rd_data(mem_rd_data), .sck_line(sck_line), .data_line(data_line),
        .shift_q(shift_q), .bits_q(bits_q));

    // ==========================================================
    // helpers
    function automatic logic [15:0] word_at(input logic [20:0] a);
        return a[15:0] ^ {a[20:16], 11'h000} ^ 16'hA5C3;
    endfunction : word_at

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick

    task end_of_test;
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task hang(input int i);
        if (i >= 2000) begin
            miscompares++;
            $display("unexpected %0t: wait timed out", $time);
            end_of_test;
        end
    endtask : hang

    // clear, park in standby, then stream the first two words of a range
    task read_page(input logic en, input logic [1:0] sel, input logic [20:0] start);
        int i;
        reset_oe = 1'b0;
        tick(4);
        `CHK(data_oe_n, 1'b1)
        chip_select_n = 1'b1;
        page_enable   = en;
        page_select   = sel;
        tick(4);
        `CHK(standby, 1'b1)
        reset_oe = 1'b1;
        tick(12);
        `CHK(standby, 1'b1)
        `CHK(data_oe_n, 1'b1)
        `CHK(mem_rd_req, 1'b0)
        chip_select_n = 1'b0;
        for (i = 0; i < 2000 && mem_rd_req !== 1'b1; i++) tick(1);
        hang(i);
        `CHK(mem_addr, start)
        for (i = 0; i < 2000 && data_oe_n !== 1'b0; i++) tick(1);
        hang(i);
        `CHK(standby, 1'b0)
        base = bits_q;
        for (i = 0; i < 2000 && bits_q < base + 32; i++) tick(1);
        hang(i);
        `CHK(shift_q, {word_at(start), word_at(start + 21'h000001)})
        `CHK(cascade_out_n, 1'b1)
    endtask : read_page

    // ==========================================================
    // main sequence
    initial begin
        tick(20);
        rst_n = 1'b1;
        `CHK(ready_oe_n, 1'b0)
        `CHK(ready_out, 1'b0)
        tick(5);
        `CHK(ready_oe_n, 1'b1)
        `CHK(cascade_out_n, 1'b1)
        `CHK(serial_clock_oe_n, 1'b0)
        for (k = 0; k < 4; k++) begin
            slow = k[0];
            read_page(1'b1, 2'(k), 21'(k) * PAGE_SIZE);
        end
        read_page(1'b0, 2'b11, ADDR_ZERO);
        // programming mode: pins pass through, select and page pins ignored
        chip_select_n        = 1'b1;
        page_enable          = 1'b1;
        config_mode_select_n = 1'b0;
        tick(12);
        `CHK(in_system_programming, 1'b1)
        `CHK(standby, 1'b0)
        `CHK(serial_clock_oe_n, 1'b1)
        `CHK(cascade_oe_n, 1'b1)
        `CHK(mem_rd_req, 1'b0)
        for (k = 0; k < 8; k++) begin
            sck_drv       = ~sck_drv;
            sel_drv       = k[0];
            data_drv      = k[1];
            prog_data_low = k[2];
            chip_select_n = k[0];
            tick(4);
            `CHK(prog_clock, sck_drv)
            `CHK(prog_select, sel_drv)
            `CHK(data_oe_n, ~prog_data_low)
            `CHK(data_out, 1'b0)
            `CHK(prog_data, data_line)
            `CHK(standby, 1'b0)
        end
        data_drv             = 1'b1;
        config_mode_select_n = 1'b1;
        tick(5);
        `CHK(serial_clock_oe_n, 1'b0)
        `CHK(cascade_oe_n, 1'b0)
        // second power-up reset in mid-run
        rst_n = 1'b0;
        tick(3);
        `CHK(ready_oe_n, 1'b0)
        `CHK(data_oe_n, 1'b1)
        rst_n = 1'b1;
        tick(5);
        `CHK(ready_oe_n, 1'b1)
        end_of_test;
    end
endmodule : tb_scpr_readout
